// ==== hw/mcu_dp_cfg.svh ====
// Address map, field positions, reset values and widths for the add and bit datapath
`ifndef MCU_DP_CFG_SVH
`define MCU_DP_CFG_SVH

// APB geometry
`define APB_AW 12
`define APB_DW 32

// Register byte offsets
`define INSTR_OFS 12'h000
`define WORK_OFS 12'h004
`define STATUS_OFS 12'h008
`define PRIM_PAGE 4'h1
`define SEC_PAGE 4'h2

// Address field slices
`define PAGE_HI 11
`define PAGE_LO 8
`define WORD_HI 7
`define WORD_LO 2
`define SEC_TOP_HI 7
`define SEC_TOP_LO 6

// Instruction word fields
`define INSTR_W 16
`define OPC_HI 15
`define OPC_LO 12
`define BITPOS_HI 8
`define BITPOS_LO 6
`define DEST_BIT 6
`define RADDR_HI 5
`define IMM_HI 7
`define SADDR_HI 3

// Page sizes and widths
`define PRIM_AW 6
`define SEC_AW 4
`define PRIM_DEPTH 64
`define SEC_DEPTH 16

// Status field width and reset values
`define STATUS_W 5
`define WORK_RST 8'h00
`define INSTR_RST 16'h0000
`define ARITH_RST 1'b0
`define PWR_FLAG_RST 1'b1

`endif

// ==== hw/mcu_dp_pkg.sv ====
// Types shared by the add and bit datapath modules
package mcu_dp_pkg;

    // Instruction opcodes held in the top nibble of the instruction word
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_ADD_REG_WITH_CARRY = 4'h1,
        OP_ADD_REG_TO_WORKING = 4'h2,
        OP_ADD_IMM_WITH_CARRY = 4'h3,
        OP_ADD_IMM_TO_WORKING = 4'h4,
        OP_AND_WORKING_WITH_REG = 4'h5,
        OP_CLEAR_REG_BIT = 4'h6,
        OP_SLEEP = 4'h7,
        OP_WATCHDOG_RESTART = 4'h8,
        OP_WORKING_TO_SEC = 4'h9,
        OP_SEC_TO_WORKING = 4'ha
    } opcode_t;

    typedef enum logic [1:0] {
        ALU_ADD = 2'h0,
        ALU_AND = 2'h1,
        ALU_CLRBIT = 2'h2
    } alu_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } exec_state_t;

    // Status word as software sees it, bit 0 is carry
    typedef struct packed {
        logic timeout_flag;
        logic power_down_flag;
        logic zero_flag;
        logic half_byte_carry_flag;
        logic carry_flag;
    } status_t;

    typedef struct packed {
        logic [7:0] value;
        logic carry;
        logic half_carry;
        logic zero;
    } alu_out_t;

    typedef struct packed {
        logic en;
        logic sec;
        logic [5:0] addr;
        logic [7:0] data;
    } rf_wr_t;

endpackage : mcu_dp_pkg

// ==== hw/byte_alu.sv ====
// Eight-bit adder, AND and bit-clear unit with zero, half-byte and carry results
`timescale 1ns/1ps
module byte_alu
    import mcu_dp_pkg::*;
(
    input wire alu_op_t op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    input wire logic [2:0] bit_pos,
    output alu_out_t res
);
    logic [4:0] low_sum;
    logic [4:0] high_sum;

    // Split add so the carry out of bit 3 is visible directly
    always_comb begin
        low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        high_sum = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, low_sum[4]};
        res = '0;
        unique case (op)
            ALU_ADD: begin
                res.value = {high_sum[3:0], low_sum[3:0]};
                res.carry = high_sum[4]; // RULE_14
                res.half_carry = low_sum[4]; // RULE_16
            end
            ALU_AND: res.value = a & b;
            ALU_CLRBIT: res.value = a & ~(8'h01 << bit_pos); // RULE_13
            default: res.value = a;
        endcase
        res.zero = (res.value == 8'h00); // RULE_15
    end
endmodule : byte_alu

// ==== hw/data_regfile.sv ====
// Primary and secondary register pages with one write port and two read ports
`timescale 1ns/1ps
`include "mcu_dp_cfg.svh"
module data_regfile
    import mcu_dp_pkg::*;
(
    input wire logic clk,
    input wire rf_wr_t wr,
    input wire logic rd_a_sec,
    input wire logic [5:0] rd_a_addr,
    output logic [7:0] rd_a_data,
    input wire logic rd_b_sec,
    input wire logic [5:0] rd_b_addr,
    output logic [7:0] rd_b_data
);
    // Plain data storage, so no reset: contents are undefined after power-up
    logic [7:0] prim_mem [`PRIM_DEPTH];
    logic [7:0] sec_mem [`SEC_DEPTH];

    // Single write port, the caller arbitrates
    always_ff @(posedge clk) begin
        if (wr.en && !wr.sec) begin
            prim_mem[wr.addr] <= wr.data; // RULE_05
        end
        if (wr.en && wr.sec) begin
            sec_mem[wr.addr[`SADDR_HI:0]] <= wr.data; // RULE_06
        end
    end

    // Asynchronous reads keep every instruction to one cycle
    assign rd_a_data = rd_a_sec ? sec_mem[rd_a_addr[`SADDR_HI:0]] : prim_mem[rd_a_addr];
    assign rd_b_data = rd_b_sec ? sec_mem[rd_b_addr[`SADDR_HI:0]] : prim_mem[rd_b_addr];
endmodule : data_regfile

// ==== hw/mcu_add_and_bit_datapath.sv ====
// Add, AND and bit-clear datapath with power and timeout flags behind an APB slave
//
// Functional notes
// [RULE_01] Power-down flag is 1 after reset and after watchdog restart.
// [RULE_02] Sleep instruction clears the power-down flag.
// [RULE_03] Timeout flag is 1 after reset, watchdog restart or sleep.
// [RULE_04] Watchdog timeout clears the timeout flag.
// [RULE_05] Register operands use six bits, primary page 0x00 to 0x3f.
// [RULE_06] Secondary page operands use four bits, 0x0 to 0xf.
// [RULE_07] Add register with carry sums working, register, carry; sets Z, DC, C.
// [RULE_08] Destination 0 writes working register, 1 writes addressed register.
// [RULE_09] Add register sums working and register, no carry in; Z, DC, C.
// [RULE_10] Add immediate with carry into working register; Z, DC, C.
// [RULE_11] Add immediate into working register without carry; Z, DC, C.
// [RULE_12] AND working with register to destination; only Z changes.
// [RULE_13] Bit clear zeroes one selected bit; flags untouched; one cycle.
// [RULE_14] Carry is the carry out of the eight-bit sum.
// [RULE_15] Zero flag set when the eight-bit result is zero.
// [RULE_16] Half-byte carry is the carry from bit 3 into bit 4.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "mcu_dp_cfg.svh"
module mcu_add_and_bit_datapath
    import mcu_dp_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`APB_AW-1:0] paddr,
    input wire logic [`APB_DW-1:0] pwdata,
    output logic [`APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wdt_timeout,
    output logic [7:0] working_register,
    output status_t status,
    output logic exec_done
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic ack_reg;
    logic err_reg;
    logic [`APB_DW-1:0] prdata_reg;
    logic [`INSTR_W-1:0] instr_reg;
    exec_state_t state_reg;
    logic exec_done_reg;
    logic [7:0] work_reg;
    logic [7:0] work_next;
    logic carry_reg;
    logic half_carry_reg;
    logic zero_reg;
    logic power_down_reg;
    logic timeout_reg;

    logic access;
    logic fire;
    logic wr_fire;
    logic hit_instr;
    logic hit_work;
    logic hit_status;
    logic hit_prim;
    logic hit_sec;
    logic hit_any;
    logic [`APB_DW-1:0] rd_mux;

    opcode_t opc;
    logic dest;
    logic [5:0] raddr;
    logic [2:0] bit_pos;
    logic [7:0] imm;
    logic executing;

    alu_op_t alu_op;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic alu_cin;
    alu_out_t alu_res;

    logic [7:0] rf_rd_apb;
    logic [7:0] rf_rd_exec;
    logic exec_rd_sec;
    rf_wr_t exec_wr;
    rf_wr_t apb_wr;
    rf_wr_t rf_wr;

    logic work_load;
    logic arith_load;
    logic zero_only_load;

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    // One wait state: data is captured on the first access cycle, so a
    // read that follows an instruction at once sees its result
    assign access = psel && penable;
    assign fire = access && ack_reg;
    assign wr_fire = fire && pwrite;
    assign pready = fire;
    assign pslverr = fire && err_reg;

    // Address match, word aligned only
    always_comb begin
        hit_instr = (paddr == `INSTR_OFS);
        hit_work = (paddr == `WORK_OFS);
        hit_status = (paddr == `STATUS_OFS);
        hit_prim = (paddr[`PAGE_HI:`PAGE_LO] == `PRIM_PAGE) && (paddr[1:0] == 2'h0);
        hit_sec = (paddr[`PAGE_HI:`PAGE_LO] == `SEC_PAGE) && (paddr[1:0] == 2'h0)
            && (paddr[`SEC_TOP_HI:`SEC_TOP_LO] == 2'h0);
        hit_any = hit_instr || hit_work || hit_status || hit_prim || hit_sec;
    end

    // Read mux, unused upper bits read as zero
    always_comb begin
        rd_mux = '0;
        if (hit_instr) begin
            rd_mux[`INSTR_W-1:0] = instr_reg;
        end else if (hit_work) begin
            rd_mux[7:0] = work_reg;
        end else if (hit_status) begin
            rd_mux[`STATUS_W-1:0] = status;
        end else if (hit_prim || hit_sec) begin
            rd_mux[7:0] = rf_rd_apb;
        end
    end

    // Wait-state flag, read data and error capture
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            prdata_reg <= '0;
        end else if (fire) begin
            ack_reg <= 1'b0;
        end else if (access) begin
            ack_reg <= 1'b1;
            err_reg <= !hit_any;
            prdata_reg <= (hit_any && !pwrite) ? rd_mux : '0;
        end
    end

    assign prdata = prdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Instruction register and sequencer

    // A write to the instruction register launches it on the next cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            instr_reg <= `INSTR_RST;
            state_reg <= ST_IDLE;
            exec_done_reg <= 1'b0;
        end else begin
            exec_done_reg <= (state_reg == ST_EXEC);
            unique case (state_reg)
                ST_IDLE: begin
                    if (wr_fire && hit_instr) begin
                        instr_reg <= pwdata[`INSTR_W-1:0];
                        state_reg <= ST_EXEC;
                    end
                end
                ST_EXEC: state_reg <= ST_IDLE; // RULE_07 RULE_09 RULE_10 RULE_11 RULE_12 RULE_13
            endcase
        end
    end

    assign executing = (state_reg == ST_EXEC);
    assign exec_done = exec_done_reg;

    // Instruction fields
    always_comb begin
        opc = opcode_t'(instr_reg[`OPC_HI:`OPC_LO]);
        dest = instr_reg[`DEST_BIT];
        raddr = instr_reg[`RADDR_HI:0]; // RULE_05
        bit_pos = instr_reg[`BITPOS_HI:`BITPOS_LO];
        imm = instr_reg[`IMM_HI:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Operand selection and result steering

    // Operands, carry input and destinations per opcode
    always_comb begin
        alu_op = ALU_ADD;
        alu_a = work_reg;
        alu_b = rf_rd_exec;
        alu_cin = 1'b0;
        exec_rd_sec = 1'b0;
        exec_wr = '0;
        work_next = work_reg;
        work_load = 1'b0;
        arith_load = 1'b0;
        zero_only_load = 1'b0;
        if (executing) begin
            unique case (opc)
                OP_ADD_REG_WITH_CARRY, OP_ADD_REG_TO_WORKING: begin
                    alu_cin = (opc == OP_ADD_REG_WITH_CARRY) && carry_reg; // RULE_07 RULE_09
                    arith_load = 1'b1;
                    work_load = !dest; // RULE_08
                    exec_wr = '{en: dest, sec: 1'b0, addr: raddr, data: alu_res.value}; // RULE_08
                end
                OP_ADD_IMM_WITH_CARRY, OP_ADD_IMM_TO_WORKING: begin
                    alu_b = imm;
                    alu_cin = (opc == OP_ADD_IMM_WITH_CARRY) && carry_reg; // RULE_10 RULE_11
                    arith_load = 1'b1;
                    work_load = 1'b1;
                end
                OP_AND_WORKING_WITH_REG: begin
                    alu_op = ALU_AND;
                    zero_only_load = 1'b1; // RULE_12
                    work_load = !dest;
                    exec_wr = '{en: dest, sec: 1'b0, addr: raddr, data: alu_res.value}; // RULE_08
                end
                OP_CLEAR_REG_BIT: begin
                    alu_op = ALU_CLRBIT;
                    alu_a = rf_rd_exec;
                    exec_wr = '{en: 1'b1, sec: 1'b0, addr: raddr, data: alu_res.value}; // RULE_13
                end
                OP_WORKING_TO_SEC: begin
                    exec_wr = '{en: 1'b1, sec: 1'b1, addr: {2'h0, raddr[`SADDR_HI:0]}, data: work_reg}; // RULE_06
                end
                OP_SEC_TO_WORKING: begin
                    exec_rd_sec = 1'b1; // RULE_06
                    work_load = 1'b1;
                end
                default: ;
            endcase
            if (work_load) begin
                work_next = (opc == OP_SEC_TO_WORKING) ? rf_rd_exec : alu_res.value;
            end
        end
    end

    byte_alu u_alu (
        .op(alu_op),
        .a(alu_a),
        .b(alu_b),
        .cin(alu_cin),
        .bit_pos(bit_pos),
        .res(alu_res)
    );

    // A software page write is dropped in a cycle where the running instruction writes a page
    always_comb begin
        apb_wr = '{en: wr_fire && (hit_prim || hit_sec), sec: hit_sec,
            addr: paddr[`WORD_HI:`WORD_LO], data: pwdata[7:0]};
        rf_wr = exec_wr.en ? exec_wr : apb_wr;
    end

    data_regfile u_rf (
        .clk(clk),
        .wr(rf_wr),
        .rd_a_sec(hit_sec),
        .rd_a_addr(paddr[`WORD_HI:`WORD_LO]),
        .rd_a_data(rf_rd_apb),
        .rd_b_sec(exec_rd_sec),
        .rd_b_addr(raddr),
        .rd_b_data(rf_rd_exec)
    );

    ////////////////////////////////////////////////////////////////////////
    // Working register

    // Instruction result or direct software load
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            work_reg <= `WORK_RST;
        end else if (work_load) begin
            work_reg <= work_next; // RULE_08
        end else if (wr_fire && hit_work) begin
            work_reg <= pwdata[7:0];
        end
    end

    assign working_register = work_reg;

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic flags

    // Adds load all three, AND only zero, bit clear none
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            carry_reg <= `ARITH_RST;
            half_carry_reg <= `ARITH_RST;
            zero_reg <= `ARITH_RST;
        end else if (arith_load) begin
            carry_reg <= alu_res.carry; // RULE_14
            half_carry_reg <= alu_res.half_carry; // RULE_16
            zero_reg <= alu_res.zero; // RULE_15
        end else if (zero_only_load) begin
            zero_reg <= alu_res.zero; // RULE_12
        end else if (wr_fire && hit_status) begin
            carry_reg <= pwdata[0];
            half_carry_reg <= pwdata[1];
            zero_reg <= pwdata[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-down and timeout flags, read only to software

    // Power-down: restart sets, sleep clears
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            power_down_reg <= `PWR_FLAG_RST; // RULE_01
        end else if (executing && opc == OP_WATCHDOG_RESTART) begin
            power_down_reg <= 1'b1; // RULE_01
        end else if (executing && opc == OP_SLEEP) begin
            power_down_reg <= 1'b0; // RULE_02
        end
    end

    // Timeout: a restart or sleep in the same cycle as a timeout wins,
    // so the instruction's intent is never lost
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timeout_reg <= `PWR_FLAG_RST; // RULE_03
        end else if (executing && (opc == OP_WATCHDOG_RESTART || opc == OP_SLEEP)) begin
            timeout_reg <= 1'b1; // RULE_03
        end else if (wdt_timeout) begin
            timeout_reg <= 1'b0; // RULE_04
        end
    end

    assign status = '{timeout_flag: timeout_reg, power_down_flag: power_down_reg,
        zero_flag: zero_reg, half_byte_carry_flag: half_carry_reg, carry_flag: carry_reg};

endmodule : mcu_add_and_bit_datapath

// ==== tb/mcu_dp_chk.sv ====
// Port checker for the add and bit datapath
`timescale 1ns/1ps
`include "mcu_dp_cfg.svh"
module mcu_dp_chk
    import mcu_dp_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`APB_AW-1:0] paddr,
    input wire logic [`APB_DW-1:0] pwdata,
    input wire logic [`APB_DW-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wdt_timeout,
    input wire logic [7:0] working_register,
    input wire status_t status,
    input wire logic exec_done
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    logic launch;
    logic imm;
    logic [3:0] op;
    logic cin_use;
    logic set_pend;
    logic [8:0] sum9;
    logic [4:0] sum5;

    // Instruction launch at the completing APB edge
    assign launch = psel && penable && pready && pwrite && paddr == `INSTR_OFS;
    assign op = pwdata[`OPC_HI:`OPC_LO];
    assign imm = op == 4'h3 || op == 4'h4;
    assign cin_use = op == 4'h3 && status.carry_flag;
    assign sum9 = working_register + pwdata[7:0] + cin_use;
    assign sum5 = working_register[3:0] + pwdata[3:0] + cin_use;

    // Sleep or restart in flight, which beats a same-cycle timeout
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            set_pend <= 1'h0;
        end else begin
            set_pend <= launch && (op == 4'h7 || op == 4'h8);
        end
    end

    ////////////////////////////////////////
    sequence one_wait;
        !pready ##1 pready;
    endsequence
    sequence done_pulse;
        !exec_done ##1 exec_done ##1 !exec_done;
    endsequence

    chk_apb_wait: assert property ($rose(penable) && psel |-> one_wait)
        else $error("pready not in second access cycle");
    chk_done_pulse: assert property (launch && op != 4'h0 && op < 4'hb |=> done_pulse)
        else $error("exec_done not a one-cycle pulse");
    chk_sleep_flags: assert property (launch && op == 4'h7 |-> ##2 !status.power_down_flag && status.timeout_flag)
        else $error("sleep flags wrong");
    chk_restart_flags: assert property (launch && op == 4'h8 |-> ##2 status.power_down_flag && status.timeout_flag)
        else $error("restart flags wrong");
    chk_wdt_clear: assert property (wdt_timeout && !set_pend |=> !status.timeout_flag)
        else $error("timeout flag not cleared");
    chk_clrbit_keep: assert property (launch && op == 4'h6 |=> $stable(status[2:0]) [*2])
        else $error("bit clear changed flags");
    chk_and_keep: assert property (launch && op == 4'h5 |=> $stable(status[1:0]) [*2])
        else $error("AND changed carry flags");
    chk_imm_sum: assert property (launch && imm |-> ##2 {status.carry_flag, working_register} == $past(sum9, 2))
        else $error("immediate add result wrong");
    chk_half_carry: assert property (launch && imm |-> ##2 status.half_byte_carry_flag == $past(sum5[4], 2))
        else $error("half-byte carry wrong");
    chk_zero_flag: assert property (launch && imm |-> ##2 status.zero_flag == (working_register == 8'h00))
        else $error("zero flag wrong");
endmodule : mcu_dp_chk

bind mcu_add_and_bit_datapath mcu_dp_chk mcu_dp_chk_i (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wdt_timeout(wdt_timeout),
    .working_register(working_register), .status(status), .exec_done(exec_done));

// ==== tb/tb_mcu_add_and_bit_datapath.sv ====
// Self-checking bench for the add and bit datapath
`timescale 1ns/1ps
`include "mcu_dp_cfg.svh"
module tb_mcu_add_and_bit_datapath
    import mcu_dp_pkg::*;
;
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic wdt_timeout = 1'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic exec_done;
    logic [7:0] working_register;
    status_t status;
    int bad_count = 0;
    int n_tests = 0;
    logic [31:0] rd;
    logic err;
    logic [7:0] res;
    // Case tables: opcode, destination, address, working, operand, carry
    logic [3:0] co [4] = '{4'h1, 4'h2, 4'h1, 4'h2};
    logic cd [4] = '{1'h1, 1'h0, 1'h0, 1'h1};
    logic [5:0] ca [4] = '{6'h05, 6'h3f, 6'h00, 6'h20};
    logic [7:0] cw [4] = '{8'h12, 8'h12, 8'hf8, 8'h88};
    logic [7:0] cr [4] = '{8'h34, 8'h34, 8'h07, 8'h88};
    logic cc [4] = '{1'h1, 1'h1, 1'h1, 1'h0};

    // 50 MHz clock
    always #10 clk = ~clk;

    mcu_add_and_bit_datapath mcu_add_and_bit_datapath_i (.clk(clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wdt_timeout(wdt_timeout),
        .working_register(working_register), .status(status), .exec_done(exec_done));

    ////////////////////////////////////////
    task automatic give_verdict;
        $display("Counts: %0d compared, %0d mismatched", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            cmp("pready", 32'h1, 32'h0);
            give_verdict();
        end
    endtask : apb

    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        cmp(what, exp, rd);
    endtask : rdc

    task automatic run(input logic [3:0] o, input logic [11:0] f);
        apb(1'h1, `INSTR_OFS, {16'h0, o, f});
    endtask : run

    function automatic logic [11:0] rega(input logic [5:0] n);
        return {4'h1, n, 2'h0};
    endfunction : rega

    // Expected status with both power flags still set
    function automatic logic [31:0] add_st(input logic [7:0] a, input logic [7:0] b, input logic c);
        logic [8:0] s;
        logic [4:0] h;
        s = a + b + c;
        h = a[3:0] + b[3:0] + c;
        return {27'h0, 2'h3, s[7:0] == 8'h00, h[4], s[8]};
    endfunction : add_st

    ////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'h1;
        rdc("status", `STATUS_OFS, 32'h18);
        rdc("working", `WORK_OFS, 32'h0);
        $display("reset test done");
        // Register adds, both destinations, page ends
        for (int k = 0; k < 4; k++) begin
            apb(1'h1, `WORK_OFS, {24'h0, cw[k]});
            apb(1'h1, rega(ca[k]), {24'h0, cr[k]});
            apb(1'h1, `STATUS_OFS, {31'h0, cc[k]});
            run(co[k], {5'h0, cd[k], ca[k]});
            res = cw[k] + cr[k] + (co[k] == 4'h1 && cc[k]);
            rdc("status", `STATUS_OFS, add_st(cw[k], cr[k], co[k] == 4'h1 && cc[k]));
            rdc("working", `WORK_OFS, {24'h0, cd[k] ? cw[k] : res});
            rdc("register", rega(ca[k]), {24'h0, cd[k] ? res : cr[k]});
        end
        $display("register add test done");
        // Immediate adds, with and without carry in
        for (int k = 0; k < 4; k++) begin
            apb(1'h1, `WORK_OFS, {24'h0, cw[k] + 8'h01});
            apb(1'h1, `STATUS_OFS, {31'h0, cc[k]});
            run(co[k] + 4'h2, {4'h0, cr[k]});
            res = cw[k] + 8'h01 + cr[k] + (co[k] == 4'h1 && cc[k]);
            rdc("status", `STATUS_OFS, add_st(cw[k] + 8'h01, cr[k], co[k] == 4'h1 && cc[k]));
            rdc("working", `WORK_OFS, {24'h0, res});
        end
        $display("immediate add test done");
        // AND keeps carry flags, to both destinations
        for (int k = 0; k < 2; k++) begin
            apb(1'h1, `WORK_OFS, {24'h0, k ? 8'hf0 : 8'h5a});
            apb(1'h1, rega(6'h02), {24'h0, k ? 8'h3c : 8'ha5});
            apb(1'h1, `STATUS_OFS, 32'h3);
            run(4'h5, {5'h0, k[0], 6'h02});
            rdc("status", `STATUS_OFS, k ? 32'h1b : 32'h1f);
            rdc("and result", k ? rega(6'h02) : `WORK_OFS, k ? 32'h30 : 32'h0);
        end
        $display("and test done");
        // Clear every bit position in turn
        apb(1'h1, rega(6'h07), 32'hff);
        apb(1'h1, `STATUS_OFS, 32'h5);
        for (int b = 0; b < 8; b++) begin
            run(4'h6, {3'h0, b[2:0], 6'h07});
            res = 8'hff << (b + 1);
            rdc("bit clear", rega(6'h07), {24'h0, res});
        end
        rdc("status", `STATUS_OFS, 32'h1d);
        $display("bit clear test done");
        // Secondary page both ways and an unmapped word
        apb(1'h1, 12'h23c, 32'h5c);
        rdc("secondary", 12'h23c, 32'h5c);
        apb(1'h1, `WORK_OFS, 32'h3a);
        run(4'h9, 12'h00f);
        rdc("secondary", 12'h23c, 32'h3a);
        apb(1'h1, `WORK_OFS, 32'h0);
        run(4'ha, 12'h00f);
        rdc("working", `WORK_OFS, 32'h3a);
        rdc("unmapped", 12'h240, 32'h0);
        cmp("pslverr", 32'h1, {31'h0, err});
        $display("page test done");
        // Power flags through sleep, timeout and restart
        run(4'h7, 12'h000);
        rdc("status", `STATUS_OFS, 32'h15);
        @(posedge clk);
        wdt_timeout <= 1'h1;
        @(posedge clk);
        wdt_timeout <= 1'h0;
        rdc("status", `STATUS_OFS, 32'h05);
        run(4'h8, 12'h000);
        rdc("status", `STATUS_OFS, 32'h1d);
        @(posedge clk);
        wdt_timeout <= 1'h1;
        @(posedge clk);
        wdt_timeout <= 1'h0;
        apb(1'h1, `STATUS_OFS, 32'h1a);
        rdc("status", `STATUS_OFS, 32'h0a);
        run(4'h7, 12'h000);
        rdc("status", `STATUS_OFS, 32'h12);
        $display("power flag test done");
        give_verdict();
    end
endmodule : tb_mcu_add_and_bit_datapath
